/* common/dpts_defs.svh */
// Timing counts and field positions for the token semaphore port controller.
`ifndef DPTS_DEFS_SVH
`define DPTS_DEFS_SVH

`define DPTS_DATA_W      16
`define DPTS_IDX_W       3
`define DPTS_ADDR_W      14
`define DPTS_NUM_TOKENS  8
`define DPTS_TOKEN_BIT   0
// Strobe low time and select-inactive gap, in ns and in 40 MHz cycles.
`define DPTS_CLK_NS      25
`define DPTS_STROBE_NS   50
`define DPTS_STROBE_CYC  ((`DPTS_STROBE_NS + `DPTS_CLK_NS - 1) / `DPTS_CLK_NS)
`define DPTS_GAP_NS      50
`define DPTS_GAP_CYC     ((`DPTS_GAP_NS + `DPTS_CLK_NS - 1) / `DPTS_CLK_NS)

`endif

/* common/dpts_pkg.sv */
// Types for the token semaphore port controller.
package dpts_pkg;
  typedef enum logic [1:0] {
    DPTS_OP_REQUEST,
    DPTS_OP_RELEASE,
    DPTS_OP_POLL,
    DPTS_OP_INIT
  } dpts_op_t;

  typedef enum logic [2:0] {
    DPTS_IDLE,
    DPTS_WRITE,
    DPTS_READ,
    DPTS_GAP,
    DPTS_DONE
  } dpts_state_t;
endpackage

/* rtl/dpts_host.sv */
// Host-side controller that drives one port of the token semaphore space.
`include "dpts_defs.svh"

module dpts_host
  import dpts_pkg::*;
(
  // Clock and reset
  input  wire logic                        mclk_i,
  input  wire logic                        rst_b_i,
  // Command port
  input  wire logic                        cmd_valid_i,
  output logic                             cmd_ready_o,
  input  wire dpts_pkg::dpts_op_t          cmd_op_i,
  input  wire logic [`DPTS_IDX_W-1:0]      cmd_index_i,
  output logic                             rsp_valid_o,
  output logic                             rsp_owned_o,
  output logic                             rsp_error_o,
  // Device port pins
  output logic                             array_select_n_o,
  output logic                             flag_space_select_n_o,
  output logic                             write_n_o,
  output logic                             read_drive_n_o,
  output logic [`DPTS_ADDR_W-1:0]          addr_o,
  output logic [`DPTS_DATA_W-1:0]          data_o,
  output logic                             data_oe_o,
  input  wire logic [`DPTS_DATA_W-1:0]     data_i
);
  import dpts_pkg::*;

  // ****************************************************************
  // Input synchroniser
  // ****************************************************************
  // The device is clockless, so its read data is an asynchronous input.
  logic [`DPTS_DATA_W-1:0] data_s1_q;
  logic [`DPTS_DATA_W-1:0] data_s2_q;

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      data_s1_q <= '0;
      data_s2_q <= '0;
    end else begin
      data_s1_q <= data_i;
      data_s2_q <= data_s1_q;
    end
  end

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  dpts_state_t              state_q;
  dpts_state_t              state_d;
  dpts_op_t                 op_q;
  logic [`DPTS_IDX_W-1:0]   idx_q;
  logic [2:0]               cnt_q;
  logic                     wval_q;
  logic                     owned_q;
  logic                     err_q;

  localparam logic [2:0] STROBE_CYC = 3'(`DPTS_STROBE_CYC);
  localparam logic [2:0] GAP_CYC    = 3'(`DPTS_GAP_CYC);
  // The read stays open a further two cycles so the synchroniser settles.
  localparam logic [2:0] READ_CYC   = 3'(`DPTS_STROBE_CYC + 2);

  // A flag read is valid only when every data bit agrees.
  function automatic logic all_same(input logic [`DPTS_DATA_W-1:0] v);
    return (&v) | ~(|v);
  endfunction

  wire  take_cmd  = cmd_valid_i && (state_q == DPTS_IDLE);
  wire  cnt_done  = (cnt_q == 3'h0);
  wire  is_init   = (op_q == DPTS_OP_INIT);
  wire  init_last = is_init && (idx_q == 3'(`DPTS_NUM_TOKENS - 1));
  // Request writes zero, release and init write one, poll only reads.
  wire  wr_value  = (cmd_op_i != DPTS_OP_REQUEST);
  wire  rd_flag   = data_s2_q[`DPTS_TOKEN_BIT];
  wire  rd_bad    = !all_same(data_s2_q);

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      DPTS_IDLE:  if (cmd_valid_i) state_d = (cmd_op_i == DPTS_OP_POLL) ? DPTS_READ
                                                                        : DPTS_WRITE;
      DPTS_WRITE: if (cnt_done) state_d = is_init ? DPTS_GAP : DPTS_READ;
      DPTS_READ:  if (cnt_done) state_d = DPTS_GAP;
      DPTS_GAP:   if (cnt_done) state_d = (is_init && !init_last) ? DPTS_WRITE : DPTS_DONE;
      DPTS_DONE:  state_d = DPTS_IDLE;
    endcase
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_q <= DPTS_IDLE;
      op_q    <= DPTS_OP_POLL;
      idx_q   <= '0;
      cnt_q   <= '0;
      wval_q  <= 1'b1;
      owned_q <= 1'b0;
      err_q   <= 1'b0;
    end else begin
      state_q <= state_d;
      if (take_cmd) begin
        op_q    <= cmd_op_i;
        idx_q   <= (cmd_op_i == DPTS_OP_INIT) ? 3'h0 : cmd_index_i;
        wval_q  <= wr_value;
        cnt_q   <= (cmd_op_i == DPTS_OP_POLL) ? READ_CYC : STROBE_CYC;
        err_q   <= 1'b0;
        owned_q <= 1'b0;
      end else if (state_q != state_d) begin
        cnt_q <= (state_d == DPTS_READ) ? READ_CYC :
                 (state_d == DPTS_GAP)  ? GAP_CYC  : STROBE_CYC;
        // Read result sampled on the last cycle of the open read strobe.
        if (state_q == DPTS_READ) begin
          owned_q <= !rd_flag;
          err_q   <= rd_bad;
        end
        // The sweep stops on the last token so the response still names it.
        if (state_q == DPTS_GAP && is_init && !init_last) idx_q <= idx_q + 3'h1;
      end else if (!cnt_done) begin
        cnt_q <= cnt_q - 3'h1;
      end
    end
  end

  // ****************************************************************
  // Pin drive
  // ****************************************************************
  // Array select is never driven low: this controller only touches tokens.
  wire active = (state_q == DPTS_WRITE) || (state_q == DPTS_READ);

  assign array_select_n_o      = 1'b1;
  assign flag_space_select_n_o = !active;
  assign write_n_o             = (state_q != DPTS_WRITE);
  assign read_drive_n_o        = (state_q != DPTS_READ);
  assign addr_o                = {11'h000, idx_q};
  assign data_o                = {15'h0000, wval_q};
  assign data_oe_o             = (state_q == DPTS_WRITE);
  assign cmd_ready_o           = (state_q == DPTS_IDLE);
  assign rsp_valid_o           = (state_q == DPTS_DONE);
  assign rsp_owned_o           = owned_q;
  assign rsp_error_o           = err_q;

  // ****************************************************************
  // Checks
  // ****************************************************************
  chk_gap_between_reads: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    $rose(read_drive_n_o) |-> flag_space_select_n_o [*2])
    else $error("Token select not dropped between reads.");
  chk_write_before_read: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    (take_cmd && cmd_op_i == DPTS_OP_REQUEST) |=> !write_n_o [*3] ##1 !read_drive_n_o)
    else $error("Request did not write before reading.");
  chk_array_held_off: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    !flag_space_select_n_o |-> array_select_n_o)
    else $error("Array select active during token access.");
  chk_request_data: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    (!write_n_o && op_q == DPTS_OP_REQUEST) |-> (data_oe_o && data_o == 16'h0000))
    else $error("Request did not write zero.");
  chk_init_sweep: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    (take_cmd && cmd_op_i == DPTS_OP_INIT) |-> ##[1:60] (rsp_valid_o && idx_q == 3'h7))
    else $error("Init sweep did not cover all tokens.");
  chk_release_data: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    (!write_n_o && op_q == DPTS_OP_RELEASE) |-> data_o[0])
    else $error("Withdraw did not write one.");

  // ****************************************************************
  // Pin protocol checks
  // ****************************************************************
  // These guard the pin sequence the far side relies on; a short strobe would
  // only show up as a wrong token value several commands later.
  chk_write_length: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    $fell(write_n_o) |-> !write_n_o [*3])
    else $error("Token write strobe shorter than three cycles.");
  chk_read_length: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    $fell(read_drive_n_o) |-> !read_drive_n_o [*5])
    else $error("Token read strobe shorter than five cycles.");
  chk_single_strobe: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    !(!write_n_o && !read_drive_n_o))
    else $error("Write and read strobes active together.");
  // The index must not move while the token select is low.
  chk_index_steady: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    (!flag_space_select_n_o && !$past(flag_space_select_n_o)) |-> $stable(addr_o))
    else $error("Token index changed during an access.");
  chk_upper_addr: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    addr_o[`DPTS_ADDR_W-1:`DPTS_IDX_W] == '0)
    else $error("Upper address lines not held at zero.");
  chk_idle_standby: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    cmd_ready_o |-> (flag_space_select_n_o && array_select_n_o))
    else $error("Port not in standby while idle.");
  chk_rsp_pulse: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    rsp_valid_o |=> !rsp_valid_o)
    else $error("Response strobe longer than one cycle.");
  chk_init_data: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    (!write_n_o && is_init) |-> (data_oe_o && data_o == 16'h0001))
    else $error("Init sweep did not write one.");
  // A flag read whose bits disagree is reported, not retried: software decides.
  chk_poll_read_only: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    (op_q == DPTS_OP_POLL && !cmd_ready_o) |-> write_n_o)
    else $error("Poll issued a token write.");
endmodule // dpts_host

/* test/dpts_dev_model.sv */
// Behavioural two-port token device: port 0 faces the host controller, port 1 the bench.
module dpts_dev_model (
  input  wire logic       mclk_i,
  input  wire logic [1:0] ce_n_i,
  input  wire logic [1:0] flag_space_select_n_i,
  input  wire logic [1:0] we_n_i,
  input  wire logic [1:0] oe_n_i,
  input  wire logic [5:0] idx_i,
  input  wire logic [1:0] d0_i,
  output logic      [1:0] q_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] req_n [2];
  logic [1:0] own   [8];
  logic [1:0] rd_q  = 2'h0;
  logic [1:0] lat_q = 2'h0;
  wire  logic [1:0] acc = ~flag_space_select_n_i & ce_n_i;
  wire  logic [1:0] rd  = acc & ~oe_n_i;
  // Power-up leaves every request pending, so only a full clearing from both sides frees all.
  initial begin
    req_n = '{8'h00, 8'h00};
    for (int i = 0; i < 8; i++) own[i] = 2'h0;
  end
  always @(posedge mclk_i) begin
    for (int p = 0; p < 2; p++) begin
      if (acc[p] && !we_n_i[p]) req_n[p][idx_i[3*p+:3]] = d0_i[p];
      if (rd[p] && !rd_q[p]) lat_q[p] <= own[idx_i[3*p+:3]] != 2'(p + 1);
    end
    rd_q <= rd;
    for (int i = 0; i < 8; i++) begin
      if (own[i] != 2'h0 && req_n[own[i] - 2'h1][i]) own[i] = 2'h0;
      if (own[i] == 2'h0)
        own[i] = !req_n[0][i] ? 2'h1 : (!req_n[1][i] ? 2'h2 : 2'h0);
    end
  end
  // A released data bus shows the inverse of the last value, never a held copy.
  assign q_o = (rd_q & lat_q) | (~rd_q & ~lat_q);
endmodule // dpts_dev_model

/* test/tb.sv */
// Self-checking bench for the token semaphore host controller.
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import dpts_pkg::*;
  logic mclk_i = 0, rst_b_i = 0, cmd_valid_i = 0;
  dpts_op_t cmd_op_i = DPTS_OP_POLL;
  logic [2:0] cmd_index_i = 3'h0, b_idx = 3'h0, idx;
  logic b_flag_space_select_n = 1, b_we_n = 1, b_oe_n = 1, b_d0 = 1, b_glitch = 0;
  logic cmd_ready_o, rsp_valid_o, rsp_owned_o, rsp_error_o, data_oe_o;
  logic array_select_n_o, flag_space_select_n_o, write_n_o, read_drive_n_o;
  logic [13:0] addr_o;
  logic [15:0] data_o;
  logic [1:0] q;
  int mismatches = 0, checks_done = 0;
  logic [1:0] exp_q [$];
  initial forever #12.5 mclk_i = ~mclk_i;
  dpts_host i_dpts_host (.mclk_i, .rst_b_i, .cmd_valid_i, .cmd_ready_o, .cmd_op_i,
    .cmd_index_i, .rsp_valid_o, .rsp_owned_o, .rsp_error_o, .array_select_n_o,
    .flag_space_select_n_o, .write_n_o, .read_drive_n_o, .addr_o, .data_o, .data_oe_o,
    .data_i({16{q[0]}} ^ {b_glitch, 15'h0000}));
  dpts_dev_model i_dpts_dev_model (.mclk_i, .ce_n_i({1'b1, array_select_n_o}),
    .flag_space_select_n_i({b_flag_space_select_n, flag_space_select_n_o}),
    .we_n_i({b_we_n, write_n_o}),
    .oe_n_i({b_oe_n, read_drive_n_o}), .idx_i({b_idx, addr_o[2:0]}),
    .d0_i({b_d0, data_o[0]}), .q_o(q));
  task automatic chk_rsp(input logic [1:0] got, input logic [1:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t rsp got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_flag(input logic got, input logic exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t flag got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic end_sim();
    // A response that never arrived leaves its note behind.
    mismatches += exp_q.size();
    $display("checks_done=%0d mismatches=%0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic cmd(input dpts_op_t op, input logic [2:0] i, input logic e);
    exp_q.push_back({b_glitch, e});
    cmd_op_i <= op;
    cmd_index_i <= i;
    cmd_valid_i <= 1'b1;
    @(posedge mclk_i);
    cmd_valid_i <= 1'b0;
    for (int n = 0; n < 100 && rsp_valid_o !== 1'b1; n++) @(negedge mclk_i);
    if (rsp_valid_o !== 1'b1) mismatches++;
    @(posedge mclk_i);
  endtask
  task automatic b_acc(input logic [2:0] i, input logic wr, input logic v);
    b_idx <= i;
    b_d0 <= v;
    b_flag_space_select_n <= 1'b0;
    b_we_n <= !wr;
    b_oe_n <= wr;
    repeat (2) @(posedge mclk_i);
    @(negedge mclk_i);
    if (!wr) chk_flag(q[1], v);
    @(posedge mclk_i);
    b_flag_space_select_n <= 1'b1;
    b_we_n <= 1'b1;
    b_oe_n <= 1'b1;
    @(posedge mclk_i);
  endtask
  // Each response pulse is judged against the oldest expectation.
  always @(negedge mclk_i)
    if (rsp_valid_o === 1'b1)
      chk_rsp({rsp_error_o, rsp_owned_o}, exp_q.size() ? exp_q.pop_front() : 2'h3);
  initial begin
    #500000;
    mismatches++;
    end_sim();
  end
  initial begin
    void'($urandom(32'h91e1));
    repeat (6) @(posedge mclk_i);
    rst_b_i <= 1'b1;
    @(posedge mclk_i);
    cmd(DPTS_OP_INIT, 3'h0, 1'b0);
    for (int i = 0; i < 8; i++) b_acc(3'(i), 1'b1, 1'b1);
    for (int i = 0; i < 8; i++) b_acc(3'(i), 1'b0, 1'b1);
    for (int i = 0; i < 8; i++) begin
      idx = 3'($urandom_range(7));
      cmd(DPTS_OP_REQUEST, idx, 1'b1);
      b_acc(idx, 1'b0, 1'b1);
    end
    for (int i = 0; i < 8; i++) cmd(DPTS_OP_RELEASE, 3'(i), 1'b0);
    cmd(DPTS_OP_REQUEST, 3'h3, 1'b1);
    b_acc(3'h3, 1'b1, 1'b0);
    b_acc(3'h3, 1'b0, 1'b1);
    cmd(DPTS_OP_POLL, 3'h3, 1'b1);
    cmd(DPTS_OP_RELEASE, 3'h3, 1'b0);
    b_acc(3'h3, 1'b0, 1'b0);
    cmd(DPTS_OP_REQUEST, 3'h3, 1'b0);
    cmd(DPTS_OP_RELEASE, 3'h3, 1'b0);
    b_acc(3'h3, 1'b1, 1'b1);
    cmd(DPTS_OP_POLL, 3'h3, 1'b0);
    b_acc(3'h3, 1'b1, 1'b0);
    b_acc(3'h3, 1'b0, 1'b0);
    // One data bit flipped on the host's read path must be reported as an error.
    b_glitch <= 1'b1;
    @(posedge mclk_i);
    cmd(DPTS_OP_POLL, 3'h3, 1'b0);
    b_glitch <= 1'b0;
    @(posedge mclk_i);
    cmd(DPTS_OP_POLL, 3'h3, 1'b0);
    end_sim();
  end
endmodule // tb
